// *** core/ccr_pkg.sv ***
// Shared constants for the charger configuration register bank
package ccr_pkg;

  // ****************************************
  // Target address and register offsets
  // ****************************************
  localparam logic [6:0] CCR_I2C_ADDR = 7'h03;
  localparam logic [7:0] REG0_OFFSET = 8'h00;
  localparam logic [7:0] REG1_OFFSET = 8'h01;
  localparam logic [7:0] REG2_OFFSET = 8'h02;

  // ****************************************
  // Power-on values
  // ****************************************
  localparam logic [7:0] REG0_RST = 8'h9f;
  localparam logic [7:0] REG1_RST = 8'hac;
  localparam logic [7:0] REG2_RST = 8'h0f;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MINV_LSB = 4;
  localparam int ILIM_LSB = 0;
  localparam int PRESS_LSB = 6;
  localparam int OFFT_BIT = 5;
  localparam int BYPASS_BIT = 4;
  localparam int INHIBIT_BIT = 3;
  localparam int UVLO_LSB = 0;
  localparam int SWRST_BIT = 7;
  localparam int WDKICK_BIT = 6;
  localparam int CODE4_W = 4;
  localparam int CODE3_W = 3;
  localparam int ICC_W = 6;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_PERIOD_NS = 1_000_000_000;
  localparam int unsigned TICK_CYCLES_DFLT = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [4:0] PRESS_BASE_S = 5'h08;
  localparam logic [4:0] PRESS_STEP_S = 5'h04;
  localparam logic [4:0] OFF_SHORT_S = 5'h02;
  localparam logic [4:0] OFF_LONG_S = 5'h04;

endpackage

// *** core/ccr_bus_if.sv ***
// Internal register access channel between the serial target and the register bank
`timescale 1ns/1ps
interface ccr_bus_if;
  logic wr_stb;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  modport target (output wr_stb, output addr, output wr_data, input rd_data);
  modport regs (input wr_stb, input addr, input wr_data, output rd_data);
endinterface

// *** core/ccr_i2c_target.sv ***
// Two-wire serial target with register pointer and auto-increment
`timescale 1ns/1ps
module ccr_i2c_target (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_oe,
  ccr_bus_if.target bus
);
  import ccr_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_PTR = 5'b00100,
    ST_WDATA = 5'b01000,
    ST_RDATA = 5'b10000
  } ccr_i2c_state_e;

  // ****************************************
  // Pin synchronisers and bus conditions
  // ****************************************
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_prev_r;
  logic sda_prev_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_pin};
      sda_sync_r <= {sda_sync_r[0], sda_pin};
      scl_prev_r <= scl_sync_r[1];
      sda_prev_r <= sda_sync_r[1];
    end
  end

  wire scl_s = scl_sync_r[1];
  wire sda_s = sda_sync_r[1];
  wire scl_rise = scl_s & ~scl_prev_r;
  wire scl_fall = ~scl_s & scl_prev_r;
  wire start_det = scl_s & scl_prev_r & ~sda_s & sda_prev_r;
  wire stop_det = scl_s & scl_prev_r & sda_s & ~sda_prev_r;

  // ****************************************
  // Protocol engine
  // ****************************************
  ccr_i2c_state_e state_r;
  logic [3:0] cnt_r;
  logic ack_phase_r;
  logic incr_pend_r;
  logic [7:0] shreg_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic wr_stb_r;
  logic ack_drive_r;

  wire byte_done = scl_fall & ~ack_phase_r & (cnt_r == 4'h8);
  wire addr_match = (shreg_r[7:1] == CCR_I2C_ADDR);
  wire rx_state = (state_r == ST_ADDR) | (state_r == ST_PTR) | (state_r == ST_WDATA);

  assign bus.wr_stb = wr_stb_r;
  assign bus.addr = ptr_r;
  assign bus.wr_data = shreg_r;
  // Straight from the flop, which every path into idle already clears
  assign sda_oe = ack_drive_r;

  // Start and stop override everything so a confused host can always recover
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      ack_phase_r <= 1'b0;
      incr_pend_r <= 1'b0;
      shreg_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      wr_stb_r <= 1'b0;
      ack_drive_r <= 1'b0;
    end else begin
      wr_stb_r <= 1'b0;
      if (start_det) begin
        state_r <= ST_ADDR;
        cnt_r <= 4'h0;
        ack_phase_r <= 1'b0;
        ack_drive_r <= 1'b0;
      end else if (stop_det) begin
        state_r <= ST_IDLE;
        ack_drive_r <= 1'b0;
      end else if (scl_rise) begin
        if (ack_phase_r) begin
          if (state_r == ST_RDATA && sda_s) begin
            state_r <= ST_IDLE;
          end
        end else begin
          cnt_r <= cnt_r + 4'h1;
          if (rx_state) begin
            shreg_r <= {shreg_r[6:0], sda_s};
          end
        end
      end else if (scl_fall && ack_phase_r) begin
        ack_phase_r <= 1'b0;
        cnt_r <= 4'h0;
        tx_r <= bus.rd_data;
        ack_drive_r <= (state_r == ST_RDATA) & ~bus.rd_data[7];
        if (incr_pend_r) begin
          ptr_r <= ptr_r + 8'h01;
          incr_pend_r <= 1'b0;
        end
      end else if (byte_done) begin
        ack_phase_r <= 1'b1;
        ack_drive_r <= 1'b1;
        unique case (state_r)
          ST_ADDR: begin
            ack_drive_r <= addr_match;
            state_r <= !addr_match ? ST_IDLE : (shreg_r[0] ? ST_RDATA : ST_PTR);
          end
          ST_PTR: begin
            ptr_r <= shreg_r;
            state_r <= ST_WDATA;
          end
          ST_WDATA: begin
            wr_stb_r <= 1'b1;
            incr_pend_r <= 1'b1;
          end
          ST_RDATA: begin
            ack_drive_r <= 1'b0;
            ptr_r <= ptr_r + 8'h01;
          end
          ST_IDLE: begin
            ack_drive_r <= 1'b0;
          end
        endcase
      end else if (scl_fall && state_r == ST_RDATA && cnt_r != 4'h8) begin
        tx_r <= {tx_r[6:0], 1'b0};
        ack_drive_r <= ~tx_r[6];
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_foreign_addr_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (byte_done && state_r == ST_ADDR && !addr_match) |=> !sda_oe && state_r == ST_IDLE)
    else $error("foreign address was acknowledged");
  c_own_addr: cover property (@(posedge clk) disable iff (!rst_n)
    byte_done && state_r == ST_ADDR && addr_match);
endmodule

// *** core/ccr_config_top.sv ***
// Charger configuration register bank with push-to-recycle timing
// Function
// - Every register is eight bits, bit 0 least significant.
// - Answer as serial target at seven-bit address 03H only.
// - Multi-bit fields are unsigned codes mapped linearly to settings.
// - Register 0x00 loads 10011111 at power-on.
// - Bits 7:4 of 0x00 hold minimum input voltage code, default 1001.
// - Bits 3:0 of 0x00 hold input current limit code, default 1111.
// - Register 0x01 loads 10101100 at power-on.
// - Bits 7:6 of 0x01 set recycle press time, 8 s plus 4 s per step.
// - Bit 5 of 0x01 sets recycle off time: 0 is 2 s, 1 is 4 s.
// - Bit 4 of 0x01 set opens only the bypass switch; default 0.
// - Bit 3 of 0x01 inhibits charging when 1, default 1.
// - Bits 2:0 of 0x01 hold battery undervoltage code, default 100.
// - Register 0x02 loads 00001111 at power-on.
// - Watchdog expiry restores watchdog-resettable registers to defaults.
// - Pin held low past press time turns both switches off for off time.
`timescale 1ns/1ps
module ccr_config_top #(
  parameter int unsigned TICK_CYCLES = ccr_pkg::TICK_CYCLES_DFLT
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic ALERT_RECYCLE_PIN_N,
  input wire logic WDT_EXPIRE,
  output logic [ccr_pkg::CODE4_W-1:0] MIN_INPUT_VOLTAGE_CODE,
  output logic [ccr_pkg::CODE4_W-1:0] INPUT_CURRENT_LIMIT_CODE,
  output logic [ccr_pkg::CODE3_W-1:0] BATTERY_UNDERVOLTAGE_CODE,
  output logic [ccr_pkg::ICC_W-1:0] CHARGE_CURRENT_CODE,
  output logic BYPASS_SW_ON,
  output logic BATTERY_SW_ON,
  output logic CHARGE_ENABLE,
  output logic RECYCLE_ACTIVE,
  output logic WD_KICK
);
  import ccr_pkg::*;

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  typedef enum logic [2:0] {
    REC_IDLE = 3'b001,
    REC_PRESS = 3'b010,
    REC_OFF = 3'b100
  } ccr_rec_state_e;

  // ****************************************
  // Serial target
  // ****************************************
  ccr_bus_if bus ();

  ccr_i2c_target u_target (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .scl_pin(SCL_IN),
    .sda_pin(SDA_IN),
    .sda_oe(SDA_OE),
    .bus(bus.target)
  );

  // Open-drain line: only ever pulled low
  assign SDA_OUT = 1'b0;

  // ****************************************
  // Register decode
  // ****************************************
  logic [7:0] reg0_r;
  logic [7:0] reg1_r;
  logic [5:0] reg2_r;
  logic wd_kick_r;

  wire wr0 = bus.wr_stb & (bus.addr == REG0_OFFSET);
  wire wr1 = bus.wr_stb & (bus.addr == REG1_OFFSET);
  wire wr2 = bus.wr_stb & (bus.addr == REG2_OFFSET);
  wire soft_rst = wr2 & bus.wr_data[SWRST_BIT];
  wire wdt_rst = soft_rst | WDT_EXPIRE;

  // Reset and kick bits are self-clearing strobes, so they read back as zero
  wire [7:0] reg2_view = {2'b00, reg2_r};
  assign bus.rd_data = (bus.addr == REG0_OFFSET) ? reg0_r :
                       (bus.addr == REG1_OFFSET) ? reg1_r :
                       (bus.addr == REG2_OFFSET) ? reg2_view : 8'h00;

  wire [7:0] reg0_nxt = soft_rst ? REG0_RST : (wr0 ? bus.wr_data : reg0_r);
  wire [7:0] reg1_nxt = wdt_rst ? REG1_RST : (wr1 ? bus.wr_data : reg1_r);
  wire [5:0] reg2_nxt = wdt_rst ? REG2_RST[5:0] : (wr2 ? bus.wr_data[5:0] : reg2_r);

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      reg0_r <= REG0_RST;
      reg1_r <= REG1_RST;
      reg2_r <= REG2_RST[5:0];
      wd_kick_r <= 1'b0;
    end else begin
      reg0_r <= reg0_nxt;
      reg1_r <= reg1_nxt;
      reg2_r <= reg2_nxt;
      wd_kick_r <= wr2 & bus.wr_data[WDKICK_BIT] & ~soft_rst;
    end
  end

  assign MIN_INPUT_VOLTAGE_CODE = reg0_r[MINV_LSB +: CODE4_W];
  assign INPUT_CURRENT_LIMIT_CODE = reg0_r[ILIM_LSB +: CODE4_W];
  assign BATTERY_UNDERVOLTAGE_CODE = reg1_r[UVLO_LSB +: CODE3_W];
  assign CHARGE_CURRENT_CODE = reg2_r;
  assign WD_KICK = wd_kick_r;

  // ****************************************
  // Recycle timing
  // ****************************************
  // Linear code to seconds
  function automatic logic [4:0] press_seconds(input logic [1:0] code);
    logic [4:0] steps;
    steps = PRESS_STEP_S * {3'h0, code};
    press_seconds = PRESS_BASE_S + steps;
  endfunction

  logic [1:0] alert_sync_r;
  ccr_rec_state_e rec_state_r;
  ccr_rec_state_e rec_state_nxt;
  logic [31:0] tick_cnt_r;
  logic [4:0] sec_cnt_r;

  wire pin_low = ~alert_sync_r[1];
  wire tick = (tick_cnt_r == TICK_CYCLES - 32'd1);
  wire [4:0] sec_next = sec_cnt_r + 5'h01;
  wire [4:0] press_secs = press_seconds(reg1_r[PRESS_LSB +: 2]);
  wire [4:0] off_secs = reg1_r[OFFT_BIT] ? OFF_LONG_S : OFF_SHORT_S;
  wire press_done = tick & (sec_next >= press_secs);
  wire off_done = tick & (sec_next >= off_secs);

  always_comb begin
    rec_state_nxt = rec_state_r;
    unique case (rec_state_r)
      REC_IDLE: begin
        if (pin_low) begin
          rec_state_nxt = REC_PRESS;
        end
      end
      REC_PRESS: begin
        if (!pin_low) begin
          rec_state_nxt = REC_IDLE;
        end else if (press_done) begin
          rec_state_nxt = REC_OFF;
        end
      end
      REC_OFF: begin
        if (off_done) begin
          rec_state_nxt = REC_IDLE;
        end
      end
    endcase
  end

  // The one-second divider restarts with every press, so timing is not
  // shortened by a partial second already counted before the pin fell
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      alert_sync_r <= 2'h3;
      rec_state_r <= REC_IDLE;
      tick_cnt_r <= 32'h0;
      sec_cnt_r <= 5'h00;
    end else begin
      alert_sync_r <= {alert_sync_r[0], ALERT_RECYCLE_PIN_N};
      rec_state_r <= rec_state_nxt;
      tick_cnt_r <= (rec_state_r == REC_IDLE || tick) ? 32'h0 : tick_cnt_r + 32'h1;
      if (rec_state_nxt != rec_state_r) begin
        sec_cnt_r <= 5'h00;
      end else if (tick) begin
        sec_cnt_r <= sec_next;
      end
    end
  end

  // ****************************************
  // Switch controls
  // ****************************************
  wire rec_off = (rec_state_r == REC_OFF);
  wire charge_en_nxt = ~reg1_r[INHIBIT_BIT] & ~rec_off;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      BYPASS_SW_ON <= 1'b1;
      BATTERY_SW_ON <= 1'b1;
      CHARGE_ENABLE <= 1'b0;
      RECYCLE_ACTIVE <= 1'b0;
    end else begin
      BYPASS_SW_ON <= ~rec_off & ~reg1_r[BYPASS_BIT];
      BATTERY_SW_ON <= ~rec_off;
      CHARGE_ENABLE <= charge_en_nxt;
      RECYCLE_ACTIVE <= rec_off;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);

  a_soft_rst_reg0: assert property (soft_rst |=> reg0_r == REG0_RST)
    else $error("reg 0x00 not restored by soft reset");
  a_soft_rst_reg1: assert property (soft_rst |=> reg1_r == REG1_RST)
    else $error("reg 0x01 not restored by soft reset");
  a_wdt_reg2_restore: assert property (WDT_EXPIRE |=> reg2_r == REG2_RST[5:0])
    else $error("reg 0x02 not restored");
  a_wdt_reg1_restore: assert property (WDT_EXPIRE |=> reg1_r == REG1_RST)
    else $error("reg 0x01 not restored by watchdog");
  a_wdt_keeps_reg0: assert property (WDT_EXPIRE && !soft_rst && !wr0 |=> $stable(reg0_r))
    else $error("watchdog disturbed reg 0x00");
  a_write_reg0_fields: assert property (wr0 |=>
    MIN_INPUT_VOLTAGE_CODE == $past(bus.wr_data[7:4])
    && INPUT_CURRENT_LIMIT_CODE == $past(bus.wr_data[3:0]))
    else $error("reg 0x00 write lost");
  a_write_reg1_uvlo: assert property (wr1 && !WDT_EXPIRE |=>
    BATTERY_UNDERVOLTAGE_CODE == $past(bus.wr_data[2:0]))
    else $error("undervoltage code write lost");
  a_bypass_open: assert property (reg1_r[BYPASS_BIT] |=> !BYPASS_SW_ON)
    else $error("bypass switch not opened");
  a_charge_gate: assert property (##1 CHARGE_ENABLE == $past(!reg1_r[INHIBIT_BIT] && !rec_off))
    else $error("charge enable wrong");
  a_press_time: assert property (rec_state_r == REC_PRESS && rec_state_nxt == REC_OFF |->
    pin_low && sec_next >= press_secs && sec_next <= 5'h14)
    else $error("recycle started at wrong time");
  a_off_time_end: assert property (rec_off && off_done |=> rec_state_r == REC_IDLE
    ##1 BATTERY_SW_ON)
    else $error("off time not ended");
  a_recycle_off: assert property (rec_off |=> !BYPASS_SW_ON && !BATTERY_SW_ON)
    else $error("switches on during recycle");
  a_release_abort: assert property (rec_state_r == REC_PRESS && !pin_low |=>
    rec_state_r == REC_IDLE && sec_cnt_r == 5'h00)
    else $error("press release did not abort");

  c_soft_reset: cover property (soft_rst);
  c_watchdog: cover property (WDT_EXPIRE);
  c_recycle: cover property (rec_state_r == REC_PRESS ##1 rec_off);
  c_recycle_done: cover property (rec_off ##1 rec_state_r == REC_IDLE);
endmodule

// *** verification/ccr_host_model.sv ***
// Two-wire host model that reads and writes the register bank
`timescale 1ns/1ps
module ccr_host_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel
);
  import ccr_pkg::*;
  // Ten cycles a phase keeps each clock phase above the eight-cycle minimum
  localparam int HALF = 10;
  logic ack_ok;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    ack_ok = 1'b0;
  end
  task automatic hw();
    repeat (HALF) @(negedge clk);
  endtask
  // Data moves a few cycles after the clock falls, never with it
  task automatic bit_io(input logic b, output logic s);
    repeat (3) @(negedge clk);
    sda_rel = b;
    hw();
    scl = 1'b1;
    hw();
    s = sda_line;
    scl = 1'b0;
  endtask
  task automatic start();
    sda_rel = 1'b1;
    hw();
    scl = 1'b1;
    hw();
    sda_rel = 1'b0;
    hw();
    scl = 1'b0;
  endtask
  task automatic stop();
    hw();
    sda_rel = 1'b0;
    hw();
    scl = 1'b1;
    hw();
    sda_rel = 1'b1;
    hw();
  endtask
  task automatic send_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack_ok = ~s;
  endtask
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask
  task automatic write_regs(input logic [6:0] dev, input logic [7:0] ptr, input int n,
                            input logic [15:0] d, output logic acked);
    start();
    send_byte({dev, 1'b0});
    acked = ack_ok;
    if (acked) begin
      send_byte(ptr);
      for (int i = n - 1; i >= 0; i--) send_byte(d[8*i +: 8]);
    end
    stop();
  endtask
  task automatic read_regs(input logic [7:0] ptr, input int n, output logic [31:0] d);
    logic [7:0] b;
    d = 32'h0;
    start();
    send_byte({CCR_I2C_ADDR, 1'b0});
    send_byte(ptr);
    start();
    send_byte({CCR_I2C_ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      recv_byte(i == n - 1, b);
      d = {d[23:0], b};
    end
    stop();
  endtask
endmodule

// *** verification/ccr_config_top_tb_top.sv ***
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module ccr_config_top_tb_top;
  import ccr_pkg::*;
  // Short second so a whole press and off period fits in a few hundred cycles
  localparam int unsigned TICKS = 10;
  logic clk, rst_n, pin_n, wdt, scl, sda_rel, sda_out, sda_oe, sda_line, ok;
  logic [3:0] minv, ilim;
  logic [2:0] uvlo;
  logic [5:0] icc;
  logic byp, bat, chg, rec, kick;
  logic [31:0] rd;
  int failures, n_checks, cyc, kicks, recs, n;
  // Pull-up on the data line: released means high
  assign sda_line = sda_rel & ~(sda_oe & ~sda_out);
  ccr_config_top #(.TICK_CYCLES(TICKS)) DUT (
    .CORE_CLK(clk), .RESETN(rst_n), .SCL_IN(scl), .SDA_IN(sda_line),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ALERT_RECYCLE_PIN_N(pin_n),
    .WDT_EXPIRE(wdt), .MIN_INPUT_VOLTAGE_CODE(minv), .INPUT_CURRENT_LIMIT_CODE(ilim),
    .BATTERY_UNDERVOLTAGE_CODE(uvlo), .CHARGE_CURRENT_CODE(icc), .BYPASS_SW_ON(byp),
    .BATTERY_SW_ON(bat), .CHARGE_ENABLE(chg), .RECYCLE_ACTIVE(rec), .WD_KICK(kick)
  );
  ccr_host_model u_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
  // ****************************************
  // Clock, monitors and timeout
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (kick === 1'b1) kicks <= kicks + 1;
    if (rec === 1'b1) recs <= recs + 1;
    if (cyc == 40000) begin
      failures++;
      complete_run();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ptr, input int cnt, input logic [15:0] d);
    u_host.write_regs(CCR_I2C_ADDR, ptr, cnt, d, ok);
    check(ok, 1'b1);
    repeat (10) @(negedge clk);
  endtask
  task automatic rd_check(input logic [7:0] ptr, input int cnt, input logic [31:0] exp);
    u_host.read_regs(ptr, cnt, rd);
    check(rd, exp);
  endtask
  task automatic outs(input logic [7:0] r0, input logic [7:0] r1);
    check(minv, r0[7:4]);
    check(ilim, r0[3:0]);
    check(uvlo, r1[2:0]);
    check({byp, bat, chg, rec}, {~r1[4], 1'b1, ~r1[3], 1'b0});
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    pin_n = 1'b1;
    wdt = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    check(icc, REG2_RST[5:0]);
    check({kick, sda_oe}, 2'b00);
    outs(REG0_RST, REG1_RST);
    rd_check(REG0_OFFSET, 4, {REG0_RST, REG1_RST, REG2_RST, 8'h00});
    // Another target address gets no answer and changes nothing
    u_host.write_regs(7'h04, REG0_OFFSET, 1, 16'h0012, ok);
    check(ok, 1'b0);
    rd_check(REG0_OFFSET, 1, 32'h9f);
    wr(REG0_OFFSET, 2, 16'h5a13);
    outs(8'h5a, 8'h13);
    rd_check(REG0_OFFSET, 2, 32'h5a13);
    wr(8'h05, 1, 16'h0077);
    rd_check(8'h05, 1, 32'h0);
    // Watchdog expiry restores the second and third registers but leaves the first
    wdt = 1'b1;
    @(negedge clk);
    wdt = 1'b0;
    repeat (3) @(negedge clk);
    outs(8'h5a, REG1_RST);
    rd_check(REG0_OFFSET, 2, {16'h0, 8'h5a, REG1_RST});
    // A press shorter than the press time aborts without a recycle
    wr(REG1_OFFSET, 1, 16'h0000);
    pin_n = 1'b0;
    repeat (8 * TICKS - 20) @(negedge clk);
    pin_n = 1'b1;
    repeat (40) @(negedge clk);
    check(recs, 0);
    for (int c = 0; c < 4; c++) begin
      wr(REG1_OFFSET, 1, {8'h00, c[1:0], c[0], 5'h00});
      pin_n = 1'b0;
      n = 0;
      while (rec !== 1'b1 && n < 400) begin
        @(negedge clk);
        n++;
      end
      check(n >= (8 + 4 * c) * TICKS && n <= (8 + 4 * c) * TICKS + 10, 1'b1);
      check({byp, bat, chg}, 3'b000);
      pin_n = 1'b1;
      n = 0;
      while (rec === 1'b1 && n < 100) begin
        @(negedge clk);
        n++;
      end
      check(n >= (2 + 2 * c[0]) * TICKS - 3 && n <= (2 + 2 * c[0]) * TICKS + 3, 1'b1);
      repeat (3) @(negedge clk);
      check({byp, bat, chg, rec}, 4'b1110);
    end
    // Kick pulses once; soft reset restores all three registers
    wr(REG2_OFFSET, 1, 16'h0040);
    check(kicks, 1);
    check(icc, 6'h00);
    wr(REG0_OFFSET, 1, 16'h0033);
    wr(REG2_OFFSET, 1, 16'h0080);
    outs(REG0_RST, REG1_RST);
    rd_check(REG0_OFFSET, 3, {8'h00, REG0_RST, REG1_RST, REG2_RST});
    complete_run();
  end
endmodule
